// file: core/amc_mram_ctrl.v
`timescale 1ns/10ps
`include "amc_consts.vh"
module amc_mram_ctrl #(
  parameter STARTUP_CYC = `AMC_STARTUP_CYC,
  parameter WAKE_CYC    = `AMC_WAKE_CYC
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // user request side
  input  wire        reqValid,
  input  wire        reqWrite,
  input  wire        reqSelEnd,
  input  wire [22:0] reqAddr,
  input  wire [7:0]  reqData,
  input  wire        sleepReq,
  output wire        reqReady,
  output reg         rspValid,
  output reg  [7:0]  rspData,
  output reg         rspErr,
  output reg         flagInitDone,
  // memory pins
  output reg  [22:0] memAddr,
  output reg  [3:0]  memSelN,
  output reg         memSelAllN,
  output reg         memStrobeN,
  output reg         memOutEnN,
  output reg         memSleep,
  input  wire [7:0]  memDqIn,
  output reg  [7:0]  memDqOut,
  output reg         memDqOe,
  input  wire        memErrN
);
  localparam S_START = 4'h0;
  localparam S_INIT  = 4'h1;
  localparam S_IDLE  = 4'h2;
  localparam S_RD    = 4'h3;
  localparam S_WZ    = 4'h4;
  localparam S_WP    = 4'h5;
  localparam S_HOLD  = 4'h6;
  localparam S_SLP   = 4'h7;
  localparam S_WAKE  = 4'h8;
  localparam S_GAP   = 4'h9;
  reg [3:0]  stateReg;
  reg [20:0] cntReg;
  reg [1:0]  dieReg;
  reg        initReg;
  reg        selEndReg;
  // a request is taken only in idle with no sleep pending
  assign reqReady = (stateReg == S_IDLE) && !sleepReq;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stateReg     <= S_START;
      cntReg       <= 21'h00_0000;
      dieReg       <= 2'h0;
      initReg      <= 1'b0;
      selEndReg    <= 1'b0;
      rspValid     <= 1'b0;
      rspData      <= 8'h00;
      rspErr       <= 1'b0;
      flagInitDone <= 1'b0;
      memAddr      <= 23'h00_0000;
      memSelN      <= 4'hF;
      memSelAllN   <= 1'b1;
      memStrobeN   <= 1'b1;
      memOutEnN    <= 1'b1;
      memSleep     <= 1'b0;
      memDqOut     <= 8'h00;
      memDqOe      <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      case (stateReg)
        S_START: begin
          // power-up wait, selects and strobe held high
          cntReg <= cntReg + 21'h00_0001;
          if (cntReg >= STARTUP_CYC - 1) begin
            cntReg  <= 21'h00_0000;
            dieReg  <= 2'h0;
            initReg <= 1'b0;
            stateReg <= S_INIT;
          end
        end
        S_INIT: begin
          // step unified select through every die to define the flag
          memSelAllN <= 1'b0;
          memOutEnN  <= 1'b1;
          memStrobeN <= 1'b1;
          memDqOe    <= 1'b0;
          memAddr    <= {dieReg, 21'h00_0000};
          cntReg     <= cntReg + 21'h00_0001;
          if (cntReg >= `AMC_ACC_CYC) begin
            cntReg <= 21'h00_0000;
            dieReg <= dieReg + 2'h1;
            if (dieReg == 2'h3) begin
              memSelAllN   <= 1'b1;
              initReg      <= 1'b1;
              flagInitDone <= 1'b1;
              stateReg     <= S_IDLE;
            end
          end
        end
        S_IDLE: begin
          cntReg <= 21'h00_0000;
          if (sleepReq) begin
            memSelN    <= 4'hF;
            memSelAllN <= 1'b1;
            memOutEnN  <= 1'b1;
            memDqOe    <= 1'b0;
            memStrobeN <= 1'b1;
            memSleep   <= 1'b1;
            flagInitDone <= 1'b0;
            stateReg   <= S_SLP;
          end else if (reqValid) begin
            memAddr    <= reqAddr;
            memSelAllN <= 1'b0;
            selEndReg  <= reqSelEnd;
            if (reqWrite) begin
              memOutEnN  <= 1'b1;
              memStrobeN <= 1'b0;
              memDqOut   <= reqData;
              stateReg   <= S_WZ;
            end else begin
              memOutEnN <= 1'b0;
              stateReg  <= S_RD;
            end
          end
        end
        S_RD: begin
          // select and output enable held for the access time
          cntReg <= cntReg + 21'h00_0001;
          if (cntReg >= `AMC_ACC_CYC - 1) begin
            rspData    <= memDqIn;
            rspErr     <= initReg && !memErrN;
            rspValid   <= 1'b1;
            memSelAllN <= 1'b1;
            memOutEnN  <= 1'b1;
            stateReg   <= S_GAP;
          end
        end
        S_WZ: begin
          // strobe already low, data waits for the output-off delay
          cntReg <= cntReg + 21'h00_0001;
          if (cntReg >= `AMC_WLQZ_CYC - 1) begin
            memDqOe  <= 1'b1;
            stateReg <= S_WP;
          end
        end
        S_WP: begin
          // pulse counted from the strobe fall, ended on the chosen edge
          cntReg <= cntReg + 21'h00_0001;
          if (cntReg >= `AMC_WP_CYC - 1) begin
            cntReg <= 21'h00_0000;
            if (selEndReg)
              memSelAllN <= 1'b1;
            else
              memStrobeN <= 1'b1;
            stateReg <= S_HOLD;
          end
        end
        S_HOLD: begin
          // address and data kept one cycle past the ending edge
          cntReg <= cntReg + 21'h00_0001;
          if (cntReg >= `AMC_HOLD_CYC - 1) begin
            memDqOe    <= 1'b0;
            memSelAllN <= 1'b1;
            memStrobeN <= 1'b1;
            rspValid   <= 1'b1;
            stateReg   <= S_GAP;
          end
        end
        S_GAP: begin
          // one quiet cycle between transfers
          cntReg   <= 21'h00_0000;
          stateReg <= S_IDLE;
        end
        S_SLP: begin
          // sleep pin released only with every select and the strobe high
          if (cntReg < `AMC_SLEEP_IN_CYC)
            cntReg <= cntReg + 21'h00_0001;
          else if (!sleepReq && memSelAllN && memStrobeN) begin
            memSleep <= 1'b0;
            cntReg   <= 21'h00_0000;
            stateReg <= S_WAKE;
          end
        end
        S_WAKE: begin
          // wake wait before the flag is initialised again
          cntReg <= cntReg + 21'h00_0001;
          if (cntReg >= WAKE_CYC - 1) begin
            cntReg   <= 21'h00_0000;
            dieReg   <= 2'h0;
            initReg  <= 1'b0;
            stateReg <= S_INIT;
          end
        end
        default: stateReg <= S_START;
      endcase
    end
  end
endmodule // amc_mram_ctrl

// file: core/amc_consts.vh
`ifndef AMC_CONSTS_VH
`define AMC_CONSTS_VH
// clock period in ns
`define AMC_CLK_NS 10
// startup wait after supply good, in ns
`define AMC_STARTUP_NS 2000000
`define AMC_STARTUP_CYC (`AMC_STARTUP_NS / `AMC_CLK_NS)
// sleep entry time, ns
`define AMC_SLEEP_IN_NS 40
`define AMC_SLEEP_IN_CYC ((`AMC_SLEEP_IN_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
// wake initialisation wait, ns
`define AMC_WAKE_NS 100000
`define AMC_WAKE_CYC (`AMC_WAKE_NS / `AMC_CLK_NS)
// write pulse width, ns
`define AMC_WP_NS 50
`define AMC_WP_CYC ((`AMC_WP_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
// strobe low to output off, ns
`define AMC_WLQZ_NS 20
`define AMC_WLQZ_CYC ((`AMC_WLQZ_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
// select access time, ns
`define AMC_ACC_NS 50
`define AMC_ACC_CYC ((`AMC_ACC_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
// address and data hold after write end, in cycles
`define AMC_HOLD_CYC 1
// die select address bits
`define AMC_DIE_HI 22
`define AMC_DIE_LO 21
`define AMC_ADDR_W 23
`endif

// file: tb/amc_chk.sv
`timescale 1ns/10ps
module amc_chk (
  // clock and reset
  input wire        sys_clk,
  input wire        nrst,
  // user side
  input wire        sleepReq,
  // memory pins
  input wire [22:0] memAddr,
  input wire [3:0]  memSelN,
  input wire        memSelAllN,
  input wire        memStrobeN,
  input wire        memSleep,
  input wire [7:0]  memDqOut,
  input wire        memDqOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_ONE_SEL: assert property ($onehot0({~memSelN, ~memSelAllN}))
    else $error("more than one select driven");
  AST_STARTUP: assert property ($rose(nrst) |-> (memSelAllN && memStrobeN)[*8])
    else $error("access during startup");
  AST_STROBE_W: assert property ($fell(memStrobeN) |-> !memStrobeN[*5])
    else $error("write pulse too short");
  AST_DQ_WAIT: assert property ($fell(memStrobeN) |-> !memDqOe[*2])
    else $error("data driven too early");
  AST_SEL_HELD: assert property ($fell(memStrobeN) |-> !memSelAllN[*5])
    else $error("select lost during write");
  AST_HOLD: assert property ($rose(memStrobeN) |-> $stable(memAddr) && $stable(memDqOut))
    else $error("address or data moved at write end");
  AST_HOLD_SEL: assert property ($rose(memSelAllN) && !memStrobeN |->
    $stable(memAddr) && $stable(memDqOut)) else $error("address or data moved at select end");
  AST_SLEEP_IN: assert property ($rose(memSleep) |-> $past(sleepReq))
    else $error("sleep without request");
  AST_SLEEP_QUIET: assert property (memSleep |-> memSelAllN && memStrobeN && !memDqOe)
    else $error("pins active in sleep");
  AST_WAKE: assert property ($fell(memSleep) |-> (memSelAllN && memStrobeN)[*8])
    else $error("access too soon after wake");
endmodule // amc_chk

// file: tb/amc_mem_model.sv
`timescale 1ns/10ps
module amc_mem_model (
  // memory pins
  input  wire [22:0] memAddr,
  input  wire        memSelAllN,
  input  wire        memStrobeN,
  input  wire        memOutEnN,
  input  wire        memSleep,
  input  wire [7:0]  memDqOut,
  input  wire        memDqOe,
  output wire [7:0]  memDqIn,
  output wire        memErrN,
  // test controls
  input  wire        powerLow,
  input  wire        errInject
);
  localparam GLITCH_NS = 25;
  logic [7:0] mem [0:15];
  logic [3:0] seen;
  logic       glitch;
  wire  [3:0] idx = {memAddr[22:21], memAddr[1:0]};
  wire        rd = !memSleep && !memSelAllN && !memOutEnN && memStrobeN;
  initial begin
    seen = 4'h0;
    glitch = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  assign memDqIn = rd ? mem[idx] : ~mem[idx];
  assign memErrN = !(seen != 4'hf || glitch || (rd && errInject));
  task wr;
    if (!powerLow && !memSleep && memDqOe) mem[idx] = memDqOut;
  endtask
  always @(posedge memStrobeN) if (!memSelAllN) wr();
  always @(posedge memSelAllN) if (!memStrobeN) wr();
  always @(memAddr or memSelAllN) if (!memSelAllN && !memSleep) begin
    seen[{memAddr[22], memAddr[22] ^ memAddr[21]}] = 1'b1;
  end
  always @(negedge memSelAllN) begin
    glitch = 1'b1;
    #(GLITCH_NS) glitch = 1'b0;
  end
  always @(posedge memSleep) seen = 4'h0;
endmodule // amc_mem_model

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk, nrst, reqValid, reqWrite, reqSelEnd, sleepReq, powerLow, errInject, e;
  logic [22:0] reqAddr;
  logic [7:0]  reqData, q;
  wire         reqReady, rspValid, rspErr, flagInitDone, memSelAllN, memStrobeN, memOutEnN;
  wire         memSleep, memDqOe, memErrN;
  wire  [22:0] memAddr;
  wire  [7:0]  rspData, memDqIn, memDqOut;
  wire  [3:0]  memSelN;
  int          errorCnt, checked;
  amc_mram_ctrl #(.STARTUP_CYC(20), .WAKE_CYC(10)) u_amc_mram_ctrl (
    .sys_clk(sys_clk), .nrst(nrst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqSelEnd(reqSelEnd), .reqAddr(reqAddr), .reqData(reqData), .sleepReq(sleepReq),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspErr(rspErr),
    .flagInitDone(flagInitDone), .memAddr(memAddr), .memSelN(memSelN),
    .memSelAllN(memSelAllN), .memStrobeN(memStrobeN), .memOutEnN(memOutEnN),
    .memSleep(memSleep), .memDqIn(memDqIn), .memDqOut(memDqOut), .memDqOe(memDqOe),
    .memErrN(memErrN)
  );
  amc_mem_model u_amc_mem_model (
    .memAddr(memAddr), .memSelAllN(memSelAllN), .memStrobeN(memStrobeN),
    .memOutEnN(memOutEnN), .memSleep(memSleep), .memDqOut(memDqOut), .memDqOe(memDqOe),
    .memDqIn(memDqIn), .memErrN(memErrN), .powerLow(powerLow), .errInject(errInject)
  );
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task op(input logic w, input logic se, input logic [22:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 500) begin tk(1); n++; end
    {reqValid, reqWrite, reqSelEnd, reqAddr, reqData} = {1'b1, w, se, a, d};
    tk(1);
    reqValid = 0;
    n = 0;
    while (rspValid !== 1'b1 && n < 50) begin tk(1); n++; end
    chk({7'h0, rspValid}, 8'h01);
    q = rspData;
    e = rspErr;
    tk(1);
  endtask
  task waitf;
    int n;
    n = 0;
    while (flagInitDone !== 1'b1 && n < 200) begin tk(1); n++; end
    chk({7'h0, flagInitDone}, 8'h01);
    chk({4'h0, u_amc_mem_model.seen}, 8'h0f);
  endtask
  task t_write;
    int n;
    tk(5);
    chk({7'h0, reqReady}, 8'h00);
    n = 5;
    while (memSelAllN === 1'b1 && n < 100) begin
      tk(1);
      n++;
    end
    chk({7'h0, n >= 20}, 8'h01);
    waitf();
    op(1, 0, 23'h60_0001, 8'ha5);
    op(1, 1, 23'h40_0002, 8'h3c);
    op(0, 0, 23'h60_0001, 8'h00);
    chk(q, 8'ha5);
    powerLow = 1;
    op(1, 1, 23'h60_0001, 8'h5a);
    powerLow = 0;
    op(0, 0, 23'h60_0001, 8'h00);
    chk(q, 8'ha5);
  endtask
  task t_err;
    errInject = 1;
    op(0, 0, 23'h40_0002, 8'h00);
    chk({7'h0, e}, 8'h01);
    errInject = 0;
    op(0, 0, 23'h40_0002, 8'h00);
    chk({7'h0, e}, 8'h00);
    chk(q, 8'h3c);
  endtask
  task t_sleep;
    int n;
    sleepReq = 1;
    tk(4);
    chk({7'h0, memSleep}, 8'h01);
    sleepReq = 0;
    tk(3);
    chk({7'h0, reqReady}, 8'h00);
    n = 3;
    while (memSelAllN === 1'b1 && n < 100) begin
      tk(1);
      n++;
    end
    chk({7'h0, n >= 11}, 8'h01);
    waitf();
    op(0, 0, 23'h60_0001, 8'h00);
    chk(q, 8'ha5);
  endtask
  task conclude;
    if (errorCnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {nrst, reqValid, reqWrite, reqSelEnd, sleepReq, powerLow, errInject} = 7'h00;
    {reqAddr, reqData} = 31'h0;
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1;
    t_write();
    t_err();
    t_sleep();
    conclude();
  end
  initial begin
    #100000;
    errorCnt++;
    conclude();
  end
endmodule // tb_top
bind amc_mram_ctrl amc_chk u_amc_chk (
  .sys_clk(sys_clk), .nrst(nrst), .sleepReq(sleepReq), .memAddr(memAddr),
  .memSelN(memSelN), .memSelAllN(memSelAllN), .memStrobeN(memStrobeN),
  .memSleep(memSleep), .memDqOut(memDqOut), .memDqOe(memDqOe)
);
